/* hw/rst_consts.vh */
// Constants for the RC oscillator self-tune controller
`ifndef RST_CONSTS_VH
`define RST_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RST_OFF_TRIM 12'h000
`define RST_OFF_UNLOCK 12'h004
`define RST_OFF_IRQ_STAT 12'h008
`define RST_OFF_IRQ_MASK 12'h00c
`define RST_OFF_MEAS 12'h010

// ----------------------------------------
// Trim register fields
// ----------------------------------------
`define RST_B_ON 15
`define RST_B_SRC 12
`define RST_B_LOCK 11
`define RST_B_POL 10
`define RST_B_OUT_OF_RANGE_FLAG 9
`define RST_B_RANGE_IRQ_POLARITY 8
`define RST_TRIM_RESET 6'h00
`define RST_TRIM_MID 6'h20

// ----------------------------------------
// Unlock keys
// ----------------------------------------
`define RST_KEY1 32'haa996655
`define RST_KEY2 32'h556699aa

// ----------------------------------------
// Frequency and tolerance
// ----------------------------------------
`define RST_NOM_HZ 8000000
`define RST_SOF_HZ 1000
`define RST_SECONDARY_CRYSTAL_OSC_HZ 32768
// Oscillator counts per SOF (1 ms) and per 32 secondary_crystal_osc periods (~1 ms)
`define RST_EXP_SOF 20'd8000
`define RST_EXP_SECONDARY_CRYSTAL_OSC 20'd7813
// 0.2 percent and 1.5 percent of about 8000 counts
`define RST_TRACK_TOL 20'd16
`define RST_RANGE_TOL 20'd120
`define RST_SECONDARY_CRYSTAL_OSC_DIV 5'd31

`endif

/* hw/rst_meas.v */
// Frequency measurement: counts oscillator ticks over one reference window
`timescale 1ns/1ps
module rst_meas (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire enable,
  input wire ref_edge,
  // Result
  output reg [19:0] count_reg,
  output reg done_reg
);
  reg [19:0] acc_reg;

  // ----------------------------------------
  // Window counter
  // ----------------------------------------
  // Each enabled clk cycle counts as one oscillator tick; the count saturates at 20'hfffff
  always @(posedge clk) begin
    if (srst || !enable) begin
      acc_reg <= 20'h00000;
      count_reg <= 20'h00000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (ref_edge) begin
        count_reg <= acc_reg;
        done_reg <= 1'b1;
        acc_reg <= 20'h00000;
      end else if (acc_reg != 20'hfffff) begin
        acc_reg <= acc_reg + 20'h00001;
      end
    end
  end
endmodule

/* hw/rst_tune.v */
// RC oscillator self-tune controller with APB register access
`timescale 1ns/1ps
`include "rst_consts.vh"
module rst_tune (
  // Clock and reset
  input wire clk,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Reference inputs as one-cycle pulses, oscillator input as a running level
  input wire osc_tick,
  input wire sof_pulse,
  input wire secondary_crystal_osc_edge,
  // Oscillator control and interrupt
  output reg [5:0] trim_value,
  output reg self_tune_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_KEY1 = 3'b010;
  localparam ST_OPEN = 3'b100;

  reg [2:0] ulk_reg;
  reg tune_on_reg;
  reg src_reg;
  reg pol_reg;
  reg range_irq_polarity_reg;
  reg lock_reg;
  reg out_of_range_flag_reg;
  reg [5:0] trim_reg;
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;
  reg [4:0] secondary_crystal_osc_div_reg;
  reg [19:0] last_reg;
  reg cond_prev_reg;
  wire [19:0] meas_count;
  wire meas_done;
  wire ref_edge;
  wire acc;
  wire wr;
  wire unlocked;
  wire [19:0] exp_count;
  // Level from the oscillator: measurement is held clear while it is stopped
  wire osc_tick_gate;
  wire [19:0] diff;
  wire fast;
  wire cond_now;
  wire cond_rise;
  wire [1:0] stat_next;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign unlocked = (ulk_reg == ST_OPEN);

  // ----------------------------------------
  // Unlock sequence
  // ----------------------------------------
  // Two key writes open one write to the trim register; any other write recloses it
  always @(posedge clk) begin
    if (srst) begin
      ulk_reg <= ST_IDLE;
    end else if (wr) begin
      case (ulk_reg)
        ST_IDLE: begin
          if (hit(paddr, `RST_OFF_UNLOCK) && pwdata == `RST_KEY1) ulk_reg <= ST_KEY1;
        end
        ST_KEY1: begin
          if (hit(paddr, `RST_OFF_UNLOCK) && pwdata == `RST_KEY2) ulk_reg <= ST_OPEN;
          else ulk_reg <= ST_IDLE;
        end
        ST_OPEN: begin
          if (hit(paddr, `RST_OFF_UNLOCK) && pwdata == `RST_KEY1) ulk_reg <= ST_KEY1;
          else ulk_reg <= ST_IDLE;
        end
        default: begin
          ulk_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Reference selection and measurement
  // ----------------------------------------
  // Crystal edges are divided by 32 so both windows last about 1 ms
  always @(posedge clk) begin
    if (srst || !tune_on_reg) begin
      secondary_crystal_osc_div_reg <= 5'd0;
    end else if (secondary_crystal_osc_edge) begin
      secondary_crystal_osc_div_reg <= secondary_crystal_osc_div_reg + 5'd1;
    end
  end

  assign ref_edge = src_reg ? sof_pulse : (secondary_crystal_osc_edge && secondary_crystal_osc_div_reg == `RST_SECONDARY_CRYSTAL_OSC_DIV);
  assign exp_count = src_reg ? `RST_EXP_SOF : `RST_EXP_SECONDARY_CRYSTAL_OSC;
  // The clock stands in for each oscillator tick, so only the running level is used
  assign osc_tick_gate = osc_tick;

  rst_meas u_meas (
    .clk(clk),
    .srst(srst),
    .enable(tune_on_reg && osc_tick_gate),
    .ref_edge(ref_edge),
    .count_reg(meas_count),
    .done_reg(meas_done)
  );

  assign fast = meas_count > exp_count;
  assign diff = fast ? (meas_count - exp_count) : (exp_count - meas_count);

  // ----------------------------------------
  // Control register and trim loop
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      tune_on_reg <= 1'b0;
      src_reg <= 1'b0;
      pol_reg <= 1'b0;
      range_irq_polarity_reg <= 1'b0;
      trim_reg <= `RST_TRIM_RESET;
      lock_reg <= 1'b0;
      out_of_range_flag_reg <= 1'b0;
      last_reg <= 20'h00000;
    end else begin
      if (wr && unlocked && hit(paddr, `RST_OFF_TRIM)) begin
        tune_on_reg <= pwdata[`RST_B_ON];
        src_reg <= pwdata[`RST_B_SRC];
        pol_reg <= pwdata[`RST_B_POL];
        range_irq_polarity_reg <= pwdata[`RST_B_RANGE_IRQ_POLARITY];
        if (!tune_on_reg) trim_reg <= pwdata[5:0];
      end
      if (!tune_on_reg) begin
        lock_reg <= 1'b0;
        out_of_range_flag_reg <= 1'b0;
      end else if (meas_done && last_reg != 20'h00000) begin
        // First window after enable is partial and is discarded
        lock_reg <= (diff > `RST_TRACK_TOL);
        out_of_range_flag_reg <= (diff > `RST_RANGE_TOL);
        // Step trim each window that is off by more than half the track tolerance; saturate rather than wrap
        if (diff > `RST_TRACK_TOL / 20'd2) begin
          if (fast && trim_reg != 6'h00) trim_reg <= trim_reg - 6'h01;
          else if (!fast && trim_reg != 6'h3f) trim_reg <= trim_reg + 6'h01;
        end
      end
      if (!tune_on_reg) last_reg <= 20'h00000;
      else if (meas_done) last_reg <= meas_count | 20'h00001;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Polarity selects presence or absence of each condition
  assign cond_now = tune_on_reg && ((lock_reg ^ ~pol_reg) || (out_of_range_flag_reg ^ ~range_irq_polarity_reg));
  assign cond_rise = cond_now && !cond_prev_reg;
  assign stat_next = (stat_reg & ~((wr && hit(paddr, `RST_OFF_IRQ_STAT)) ? pwdata[1:0] : 2'b00))
                     | {1'b0, cond_rise};

  always @(posedge clk) begin
    if (srst) begin
      cond_prev_reg <= 1'b0;
      stat_reg <= 2'b00;
      mask_reg <= 2'b00;
      self_tune_irq <= 1'b0;
      trim_value <= `RST_TRIM_RESET;
    end else begin
      cond_prev_reg <= cond_now;
      stat_reg <= stat_next;
      if (wr && hit(paddr, `RST_OFF_IRQ_MASK)) mask_reg <= pwdata[1:0];
      self_tune_irq <= |(stat_next & (wr && hit(paddr, `RST_OFF_IRQ_MASK) ? pwdata[1:0] : mask_reg));
      trim_value <= trim_reg;
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  // Zero-wait answer: pready rises in the access phase and stands one cycle
  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (hit(paddr, `RST_OFF_TRIM)) begin
          prdata <= {16'h0000, tune_on_reg, 2'b00, src_reg, lock_reg, pol_reg, out_of_range_flag_reg, range_irq_polarity_reg,
                     2'b00, trim_reg};
        end else if (hit(paddr, `RST_OFF_IRQ_STAT)) begin
          prdata <= {30'h00000000, stat_reg};
        end else if (hit(paddr, `RST_OFF_IRQ_MASK)) begin
          prdata <= {30'h00000000, mask_reg};
        end else if (hit(paddr, `RST_OFF_MEAS)) begin
          prdata <= {12'h000, meas_count};
        end else if (!hit(paddr, `RST_OFF_UNLOCK)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

/* verif/rst_ref_model.sv */
// Far-side model: USB start-of-frame stream and crystal clock edges
`timescale 1ns/1ps
module rst_ref_model (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Reference setup
  input wire [15:0] sof_per,
  input wire [15:0] secondary_crystal_osc_per,
  input wire usb_on,
  input wire secondary_crystal_osc_on,
  // Reference pulses
  output reg sof_pulse,
  output reg secondary_crystal_osc_edge
);
  reg [15:0] sof_cnt;
  reg [15:0] secondary_crystal_osc_cnt;
  // Frames come only from an attached, awake host
  always @(posedge clk) begin
    if (srst || !usb_on) begin
      sof_cnt <= 16'h0;
      sof_pulse <= 1'b0;
    end else begin
      sof_pulse <= (sof_cnt == sof_per - 16'h1);
      sof_cnt <= (sof_cnt == sof_per - 16'h1) ? 16'h0 : sof_cnt + 16'h1;
    end
  end
  // A stopped crystal gives no edges, so tuning against the crystal stalls
  always @(posedge clk) begin
    if (srst || !secondary_crystal_osc_on) begin
      secondary_crystal_osc_cnt <= 16'h0;
      secondary_crystal_osc_edge <= 1'b0;
    end else begin
      secondary_crystal_osc_edge <= (secondary_crystal_osc_cnt == secondary_crystal_osc_per - 16'h1);
      secondary_crystal_osc_cnt <= (secondary_crystal_osc_cnt == secondary_crystal_osc_per - 16'h1) ? 16'h0 : secondary_crystal_osc_cnt + 16'h1;
    end
  end
endmodule

/* verif/rst_tune_checker.sv */
// Port assertions for the self-tune controller
`timescale 1ns/1ps
`include "rst_consts.vh"
module rst_tune_checker (
  // Clock, reset and APB
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Reference and control
  input wire sof_pulse,
  input wire secondary_crystal_osc_edge,
  input wire [5:0] trim_value,
  input wire self_tune_irq
);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire irq_wr = wr && (paddr == `RST_OFF_IRQ_STAT || paddr == `RST_OFF_IRQ_MASK);
  // Trim and irq may only move shortly after a reference pulse or a write
  reg [2:0] since_evt;
  always @(posedge clk) begin
    if (srst) since_evt <= 3'h7;
    else if (sof_pulse || secondary_crystal_osc_edge || wr) since_evt <= 3'h0;
    else if (since_evt != 3'h7) since_evt <= since_evt + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  zero_wait_a: assert property (acc |-> pready) else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  unmapped_err_a: assert property (acc && paddr > `RST_OFF_MEAS |-> pslverr) else $error("no error");
  trim_step_a: assert property ($changed(trim_value) && !$past(wr) && !$past(wr, 2) |->
    trim_value == $past(trim_value) + 6'h1 || trim_value == $past(trim_value) - 6'h1) else $error("trim jump");
  trim_cause_a: assert property ($changed(trim_value) |-> since_evt != 3'h7) else $error("trim moved");
  irq_rise_a: assert property ($rose(self_tune_irq) |-> since_evt != 3'h7) else $error("irq rose");
  irq_sticky_a: assert property ($fell(self_tune_irq) |-> $past(irq_wr) || $past(irq_wr, 2))
    else $error("irq dropped");
endmodule
bind rst_tune rst_tune_checker chk_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .sof_pulse(sof_pulse), .secondary_crystal_osc_edge(secondary_crystal_osc_edge),
  .trim_value(trim_value), .self_tune_irq(self_tune_irq));

/* verif/rst_tune_tb.sv */
// Self-checking bench for the self-tune controller
`timescale 1ns/1ps
`include "rst_consts.vh"
module rst_tune_tb;
  logic clk, pready, pslverr, sof_pulse, secondary_crystal_osc_edge, irq, errv;
  logic srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, usb_on = 1'b0, secondary_crystal_osc_on = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] trim;
  logic [15:0] sof_per = 16'd8100, secondary_crystal_osc_per = 16'd244;
  integer err_count = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] ON = 32'h1 << `RST_B_ON, SRC = 32'h1 << `RST_B_SRC;
  localparam logic [31:0] POLS = (32'h1 << `RST_B_POL) | (32'h1 << `RST_B_RANGE_IRQ_POLARITY);
  localparam logic [31:0] ORP = 32'h1 << `RST_B_RANGE_IRQ_POLARITY;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  rst_ref_model ref_i (.clk(clk), .srst(srst), .sof_per(sof_per), .secondary_crystal_osc_per(secondary_crystal_osc_per), .usb_on(usb_on),
    .secondary_crystal_osc_on(secondary_crystal_osc_on), .sof_pulse(sof_pulse), .secondary_crystal_osc_edge(secondary_crystal_osc_edge));
  rst_tune uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(1'b1),
    .sof_pulse(sof_pulse), .secondary_crystal_osc_edge(secondary_crystal_osc_edge), .trim_value(trim), .self_tune_irq(irq));
  task summarize;
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk) n++; while (pready !== 1'b1 && n < 9);
    rd = prdata;
    errv = pslverr;
    chk(n < 9, "no ready");
    {psel, penable} <= 2'b00;
  endtask
  task uwr(input logic [31:0] d);
    apb(1'b1, `RST_OFF_UNLOCK, `RST_KEY1);
    apb(1'b1, `RST_OFF_UNLOCK, `RST_KEY2);
    apb(1'b1, `RST_OFF_TRIM, d);
    repeat (2) @(posedge clk);
  endtask
  task irq_is(input logic [31:0] mask, input logic [31:0] stat, input logic v, input string m);
    apb(1'b1, `RST_OFF_IRQ_MASK, mask);
    apb(1'b1, `RST_OFF_IRQ_STAT, stat);
    repeat (2) @(posedge clk);
    chk(irq === v, m);
  endtask
  task wait_irq;
    integer n;
    for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge clk);
    chk(irq === 1'b1, "no interrupt");
  endtask
  task t_reset;
    apb(1'b0, `RST_OFF_TRIM, 32'h0);
    chk(rd === 32'h0 && trim === 6'h0 && irq === 1'b0, "reset value");
    apb(1'b0, 12'h020, 32'h0);
    chk(errv === 1'b1, "unmapped read");
  endtask
  task t_unlock;
    apb(1'b1, `RST_OFF_TRIM, 32'h5);
    apb(1'b0, `RST_OFF_TRIM, 32'h0);
    chk(rd[5:0] === 6'h0, "write without unlock");
    uwr(32'h5);
    chk(trim === 6'h5, "unlocked write");
    irq_is(32'h1, 32'h0, 1'b0, "irq while off");
  endtask
  task t_sof;
    usb_on <= 1'b1;
    uwr(ON | SRC | POLS | 32'h5);
    wait_irq;
    apb(1'b0, `RST_OFF_TRIM, 32'h0);
    chk(rd[11] === 1'b1 && rd[9] === 1'b0 && trim !== 6'h5, "tracking");
    uwr(ON | SRC | POLS | 32'h3f);
    chk(trim !== 6'h3f, "trim write while tuning");
    irq_is(32'h0, 32'h0, 1'b0, "masked");
    irq_is(32'h1, 32'h0, 1'b1, "pending");
    irq_is(32'h1, 32'h1, 1'b0, "cleared");
  endtask
  task t_range;
    // Deviation already present: fire on range only, so the condition must rise anew
    uwr(ON | SRC | ORP);
    sof_per <= 16'd8200;
    wait_irq;
    apb(1'b0, `RST_OFF_TRIM, 32'h0);
    chk(rd[9] === 1'b1, "range flag");
  endtask
  task t_secondary_crystal_osc;
    usb_on <= 1'b0;
    secondary_crystal_osc_on <= 1'b1;
    uwr(ON | POLS);
    irq_is(32'h1, 32'h1, 1'b0, "cleared");
    repeat (3 * 32 * 244) @(posedge clk);
    apb(1'b0, `RST_OFF_TRIM, 32'h0);
    chk(rd[11] === 1'b0 && rd[9] === 1'b0 && irq === 1'b0, "crystal lock");
    apb(1'b0, `RST_OFF_MEAS, 32'h0);
    chk(rd[19:0] > 20'd7805 && rd[19:0] < 20'd7811, "crystal window");
    uwr(32'h0);
    uwr(32'h2a);
    chk(trim === 6'h2a, "trim after tuning off");
  endtask
  // Whole run is about 48000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 70000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_unlock;
    t_sof;
    t_range;
    t_secondary_crystal_osc;
    summarize;
  end
endmodule
